// *** verilog/spm_pkg.sv ***
// Purpose: constants for the sequential program mode controller
// Assumes: 24-bit byte address, opcodes as received on the serial input
// Notes:   shared by the design and the bench
package spm_pkg;
    localparam logic [7:0]  OP_SEQ_A     = 8'had;
    localparam logic [7:0]  OP_SEQ_B     = 8'haf;
    localparam logic [7:0]  OP_WREN      = 8'h06;
    localparam logic [7:0]  OP_WRDI      = 8'h04;
    localparam logic [7:0]  OP_TERM      = 8'hf0;
    localparam logic [7:0]  OP_RDSR1     = 8'h05;
    localparam logic [7:0]  OP_RDSR2     = 8'h35;
    localparam logic [7:0]  OP_RDSR3     = 8'h15;
    localparam logic [7:0]  OP_RDSR_IND  = 8'h65;
    localparam logic [7:0]  OP_RST_EN    = 8'h66;
    localparam logic [7:0]  OP_RST       = 8'h99;
    localparam logic [7:0]  OP_ID_JEDEC  = 8'h9f;
    localparam logic [7:0]  OP_ID_MFG    = 8'h90;
    localparam logic [7:0]  OP_ID_DUAL   = 8'h94;
    localparam logic [7:0]  OP_SUSPEND_A = 8'hb0;
    localparam logic [7:0]  OP_SUSPEND_B = 8'h75;
    localparam logic [23:0] LAST_ADDR    = 24'h01ffff;
    localparam logic [2:0]  SYNC_RST     = 3'h1;
    localparam logic [2:0]  BIT_LAST     = 3'h7;
    localparam logic [1:0]  ADDR_LAST    = 2'h2;
    localparam int          SYNC_CS      = 0;
    localparam int          SYNC_SCK     = 1;
    localparam int          SYNC_SI      = 2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OPC  = 3'b001,
        ST_ADDR = 3'b010,
        ST_DATA = 3'b011,
        ST_SKIP = 3'b100
    } spm_state_e;
endpackage : spm_pkg

// *** verilog/spm_ctrl.sv ***
// Purpose: sequential program mode command filter and byte sequencer
// Assumes: spi mode 0/3 pins sampled by clk_sys; array engine and protection on clk_sys
// Assumes: the array engine holds ready_busy_flag high for a whole program
// Notes:   query_prot/query_susp describe the block holding query_addr_q
//          they may lag query_addr_q by one cycle; the look-ahead waits for them
`timescale 1ns/1ns
`default_nettype none

module spm_ctrl
    import spm_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        cs_n_pin,
    input  wire logic        sck_pin,
    input  wire logic        si_pin,
    input  wire logic        ready_busy_flag,
    input  wire logic        query_prot,
    input  wire logic        query_susp,
    input  wire logic        wel_clr_ext,
    input  wire logic        prog_fail_evt,
    input  wire logic        status4_clr,
    output logic             cmd_accept_q,
    output logic             cmd_reject_q,
    output logic [7:0]       cmd_code_q,
    output logic             prog_start_q,
    output logic [23:0]      prog_addr_q,
    output logic [7:0]       prog_data_q,
    output logic             seq_abort_q,
    output logic [23:0]      query_addr_q,
    output logic             write_latch_flag_q,
    output logic             seq_prog_mode_flag_q,
    output logic             erase_error_flag_q,
    output logic             prog_fail_flag_q
);

    function automatic logic is_op(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
        is_op = (op == a) || (op == b);
    endfunction : is_op

    // opcodes still taken while an internal operation runs
    function automatic logic busy_ok(input logic [7:0] op);
        busy_ok = is_op(op, OP_RDSR1, OP_RDSR2) || is_op(op, OP_RDSR3, OP_RDSR_IND)
               || is_op(op, OP_SUSPEND_A, OP_SUSPEND_B) || is_op(op, OP_RST_EN, OP_RST)
               || (op == OP_TERM);
    endfunction : busy_ok

    // everything outside this list is refused in sequential mode while not busy
    function automatic logic spm_ok(input logic [7:0] op);
        spm_ok = is_op(op, OP_SEQ_A, OP_SEQ_B) || is_op(op, OP_WREN, OP_WRDI)
              || (op == OP_TERM)
              || is_op(op, OP_RDSR1, OP_RDSR2) || is_op(op, OP_RDSR3, OP_RDSR_IND)
              || is_op(op, OP_ID_JEDEC, OP_ID_MFG) || (op == OP_ID_DUAL)
              || is_op(op, OP_RST_EN, OP_RST);
    endfunction : spm_ok

    logic [2:0]  sy1_q;
    logic [2:0]  sy2_q;
    logic [2:0]  sy3_q;
    logic [2:0]  stb_q;
    logic [2:0]  stb_d;
    spm_state_e  st_q;
    spm_state_e  st_d;
    logic [2:0]  bit_q;
    logic [6:0]  sh_q;
    logic [1:0]  abyte_q;
    logic [7:0]  dat_q;
    logic        have_q;
    logic        chk_q;
    logic        chk2_q;

    // pin synchroniser: a level counts once stages two and three agree
    assign stb_d = (~(sy2_q ^ sy3_q) & sy3_q) | ((sy2_q ^ sy3_q) & stb_q);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sy1_q <= SYNC_RST;
            sy2_q <= SYNC_RST;
            sy3_q <= SYNC_RST;
            stb_q <= SYNC_RST;
        end else begin
            sy1_q <= {si_pin, sck_pin, cs_n_pin};
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
            stb_q <= stb_d;
        end
    end

    wire       cs_fall   = stb_q[SYNC_CS] & ~stb_d[SYNC_CS];
    wire       cs_rise   = ~stb_q[SYNC_CS] & stb_d[SYNC_CS];
    wire       sck_rise  = ~stb_q[SYNC_SCK] & stb_d[SYNC_SCK] & ~stb_q[SYNC_CS];
    wire [7:0] byte_d    = {sh_q, sy3_q[SYNC_SI]};
    wire       byte_done = sck_rise && (bit_q == BIT_LAST);
    wire       addr_byte = byte_done && (st_q == ST_ADDR);
    wire       data_byte = byte_done && (st_q == ST_DATA);

    // opcode classification
    wire op_byte  = byte_done && (st_q == ST_OPC);
    wire op_seq   = is_op(byte_d, OP_SEQ_A, OP_SEQ_B);
    wire op_allow = ready_busy_flag ? busy_ok(byte_d)
                  : seq_prog_mode_flag_q ? spm_ok(byte_d)
                  : 1'b1;
    wire seq_go   = op_byte && op_allow && op_seq && write_latch_flag_q;
    wire cmd_ok   = op_byte && op_allow && !op_seq;
    wire cmd_bad  = op_byte && !(op_allow && (!op_seq || write_latch_flag_q));

    // opcodes that act on the latch or the mode
    wire op_wren  = byte_d == OP_WREN;
    wire op_wrdi  = byte_d == OP_WRDI;
    wire op_term  = byte_d == OP_TERM;

    // end of a sequential frame
    wire end_data = cs_rise && (st_q == ST_DATA);
    wire complete = have_q && (bit_q == 3'h0);
    wire abort    = (end_data && !complete) || (cs_rise && (st_q == ST_ADDR));
    wire prot_end = end_data && complete && query_prot;
    wire start    = end_data && complete && !query_prot;
    wire at_last  = query_addr_q == LAST_ADDR;
    wire last_end = start && at_last;
    wire prot_ahd = chk2_q && query_prot;
    wire susp_ahd = chk2_q && query_susp;

    // write latch: a set in the same cycle as a clear wins
    wire wel_set = cmd_ok && op_wren;
    wire wel_clr = (cmd_ok && op_wrdi) || abort || prot_end
                 || last_end || prot_ahd || wel_clr_ext;
    wire wel_d   = wel_set | (write_latch_flag_q & ~wel_clr);

    wire spm_set = start && !at_last;
    wire spm_clr = last_end || prot_ahd || susp_ahd || (cmd_ok && op_term);
    wire spm_d   = (spm_set | (seq_prog_mode_flag_q & ~spm_clr)) & wel_d;

    // status four: a failure in the same cycle as a clear wins
    wire pf_d    = prog_fail_evt | (prog_fail_flag_q & ~status4_clr);
    wire ee_d    = prog_fail_evt | (erase_error_flag_q & ~status4_clr);

    wire [23:0] cnt_inc   = at_last ? query_addr_q : query_addr_q + 24'h000001;
    wire [23:0] cnt_shift = {query_addr_q[15:0], byte_d};
    wire [23:0] cnt_next  = start ? cnt_inc : (addr_byte ? cnt_shift : query_addr_q);

    // next values of the framing and data registers
    wire [2:0]  bit_d        = cs_fall ? 3'h0 : (sck_rise ? bit_q + 3'h1 : bit_q);
    wire [6:0]  sh_d         = sck_rise ? byte_d[6:0] : sh_q;
    wire [1:0]  abyte_d      = (st_q != ST_ADDR) ? 2'h0 : (byte_done ? abyte_q + 2'h1 : abyte_q);
    wire [7:0]  dat_d        = data_byte ? byte_d : dat_q;
    wire        have_d       = cs_fall ? 1'b0 : (have_q | data_byte);
    wire        chk2_d       = chk_q && seq_prog_mode_flag_q;

    // next values of the request and report registers
    wire [23:0] prog_addr_d  = start ? query_addr_q : prog_addr_q;
    wire [7:0]  prog_data_d  = start ? dat_q : prog_data_q;
    wire        seq_abort_d  = abort || prot_end;
    wire        cmd_accept_d = cmd_ok || seq_go;
    wire [7:0]  cmd_code_d   = op_byte ? byte_d : cmd_code_q;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: begin
                if (cs_fall) begin
                    st_d = ST_OPC;
                end
            end
            ST_OPC: begin
                if (cs_rise) begin
                    st_d = ST_IDLE;
                end else if (seq_go) begin
                    st_d = seq_prog_mode_flag_q ? ST_DATA : ST_ADDR;
                end else if (op_byte) begin
                    st_d = ST_SKIP;
                end
            end
            ST_ADDR: begin
                if (cs_rise) begin
                    st_d = ST_IDLE;
                end else if (byte_done && (abyte_q == ADDR_LAST)) begin
                    st_d = ST_DATA;
                end
            end
            ST_DATA, ST_SKIP: begin
                if (cs_rise) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // serial framing
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_q    <= ST_IDLE;
            bit_q   <= 3'h0;
            sh_q    <= 7'h00;
            abyte_q <= 2'h0;
        end else begin
            st_q    <= st_d;
            bit_q   <= bit_d;
            sh_q    <= sh_d;
            abyte_q <= abyte_d;
        end
    end

    // data latch keeps only the newest complete byte
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dat_q  <= 8'h00;
            have_q <= 1'b0;
        end else begin
            dat_q  <= dat_d;
            have_q <= have_d;
        end
    end

    // look-ahead check two cycles after a start, once query inputs follow the counter
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            chk_q  <= 1'b0;
            chk2_q <= 1'b0;
        end else begin
            chk_q  <= spm_set;
            chk2_q <= chk2_d;
        end
    end

    // program request toward the array engine
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prog_start_q <= 1'b0;
            prog_addr_q  <= 24'h000000;
            prog_data_q  <= 8'h00;
            seq_abort_q  <= 1'b0;
        end else begin
            prog_start_q <= start;
            prog_addr_q  <= prog_addr_d;
            prog_data_q  <= prog_data_d;
            seq_abort_q  <= seq_abort_d;
        end
    end

    // address counter: next location, or address bytes as they arrive
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            query_addr_q <= 24'h000000;
        end else begin
            query_addr_q <= cnt_next;
        end
    end

    // command report
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cmd_accept_q <= 1'b0;
            cmd_reject_q <= 1'b0;
            cmd_code_q   <= 8'h00;
        end else begin
            cmd_accept_q <= cmd_accept_d;
            cmd_reject_q <= cmd_bad;
            cmd_code_q   <= cmd_code_d;
        end
    end

    // write latch, mode and status four flags
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            write_latch_flag_q   <= 1'b0;
            seq_prog_mode_flag_q <= 1'b0;
            erase_error_flag_q   <= 1'b0;
            prog_fail_flag_q     <= 1'b0;
        end else begin
            write_latch_flag_q   <= wel_d;
            seq_prog_mode_flag_q <= spm_d;
            erase_error_flag_q   <= ee_d;
            prog_fail_flag_q     <= pf_d;
        end
    end

endmodule : spm_ctrl

`default_nettype wire

// *** testbench/spm_ctrl_properties.sv ***
// Purpose: port checks for the sequential program controller
// Assumes: pulse and flag timing as in the hand-over contract
// Notes:   bound into spm_ctrl
`timescale 1ns/1ns
`default_nettype none
module spm_ctrl_properties
    import spm_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic        query_prot,
    input wire logic        query_susp,
    input wire logic        prog_fail_evt,
    input wire logic        prog_start_q,
    input wire logic [23:0] prog_addr_q,
    input wire logic        seq_abort_q,
    input wire logic [23:0] query_addr_q,
    input wire logic        write_latch_flag_q,
    input wire logic        seq_prog_mode_flag_q,
    input wire logic        erase_error_flag_q,
    input wire logic        prog_fail_flag_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // look-ahead on the next location, two cycles after the start pulse
    sequence s_prot; prog_start_q ##2 query_prot; endsequence
    sequence s_susp; prog_start_q ##2 query_susp; endsequence
    property p_mode_latch; seq_prog_mode_flag_q |-> write_latch_flag_q; endproperty
    a_mode_latch: assert property (p_mode_latch) else $error("mode set without latch");
    property p_enter; $rose(seq_prog_mode_flag_q) |-> prog_start_q; endproperty
    a_enter: assert property (p_enter) else $error("mode entered without program start");
    property p_count; prog_start_q && prog_addr_q != LAST_ADDR |-> query_addr_q == prog_addr_q + 24'h1; endproperty
    a_count: assert property (p_count) else $error("address counter not advanced");
    property p_last; prog_start_q && prog_addr_q == LAST_ADDR |-> ##[0:1] !seq_prog_mode_flag_q && !write_latch_flag_q; endproperty
    a_last: assert property (p_last) else $error("mode kept after last location");
    property p_prot; s_prot |=> !seq_prog_mode_flag_q && !write_latch_flag_q; endproperty
    a_prot: assert property (p_prot) else $error("mode kept before protected block");
    property p_susp; s_susp |=> !seq_prog_mode_flag_q; endproperty
    a_susp: assert property (p_susp) else $error("mode kept in suspended block");
    property p_abort; seq_abort_q |-> !prog_start_q ##[0:1] !write_latch_flag_q; endproperty
    a_abort: assert property (p_abort) else $error("abort programmed or kept latch");
    property p_fail; prog_fail_evt |=> erase_error_flag_q && prog_fail_flag_q; endproperty
    a_fail: assert property (p_fail) else $error("failure flags not set");
endmodule : spm_ctrl_properties
bind spm_ctrl spm_ctrl_properties u_spm_ctrl_properties (.clk_sys, .srst, .query_prot, .query_susp,
    .prog_fail_evt, .prog_start_q, .prog_addr_q, .seq_abort_q, .query_addr_q, .write_latch_flag_q,
    .seq_prog_mode_flag_q, .erase_error_flag_q, .prog_fail_flag_q);
`default_nettype wire

// *** testbench/spm_host_model.sv ***
// Purpose: spi host model for the sequential program controller
// Assumes: mode 0, one sck period spans 8 clk_sys cycles
// Notes:   si shows the inverse of its last bit while deselected
`timescale 1ns/1ns
`default_nettype none
module spm_host_model (
    input  wire logic clk_sys,
    output var logic  cs_n_pin,
    output var logic  sck_pin,
    output var logic  si_pin
);
    initial begin
        cs_n_pin = 1'b1;
        sck_pin = 1'b0;
        si_pin = 1'b0;
    end
    // sends the low n bits of b, msb first; n not a multiple of 8 is a broken frame
    task automatic send(input logic [63:0] b, input int n);
        @(posedge clk_sys) cs_n_pin <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si_pin <= b[i];
            repeat (4) @(posedge clk_sys);
            sck_pin <= 1'b1;
            repeat (4) @(posedge clk_sys);
            sck_pin <= 1'b0;
        end
        repeat (4) @(posedge clk_sys);
        cs_n_pin <= 1'b1;
        si_pin <= ~si_pin;
        repeat (16) @(posedge clk_sys);
    endtask : send
endmodule : spm_host_model
`default_nettype wire

// *** testbench/testbench.sv ***
// Purpose: self-checking bench for the sequential program controller
// Assumes: host model drives the pins, bench drives the side inputs
// Notes:   a monitor pops the expected results as the pulses appear
`timescale 1ns/1ns
`default_nettype none
module testbench import spm_pkg::*;;
    logic        clk_sys, srst, ready_busy_flag, query_prot, query_susp, wel_clr_ext, prog_fail_evt;
    logic        status4_clr, cs_n_pin, sck_pin, si_pin, cmd_accept_q, cmd_reject_q, prog_start_q;
    logic        seq_abort_q, write_latch_flag_q, seq_prog_mode_flag_q, erase_error_flag_q, prog_fail_flag_q;
    logic [7:0]  cmd_code_q, prog_data_q, d, susp_blk;
    logic [23:0] prog_addr_q, query_addr_q;
    logic [11:0] prot_blk;
    logic [31:0] seed;
    logic [8:0]  exp_cmd[$];
    logic [32:0] exp_res[$];
    int          num_errors, checks;
    logic [7:0]  ops[35] = '{8'h06, 8'h05, 8'h35, 8'h15, 8'h65, 8'h9f, 8'h90, 8'h94, 8'h66, 8'h03, 8'h3b, 8'h20,
        8'hd8, 8'h60, 8'h02, 8'hb0, 8'hd0, 8'h7a, 8'h50, 8'h36, 8'h39, 8'h7e, 8'h98, 8'h3c, 8'h9b, 8'h4b, 8'h01,
        8'h31, 8'h71, 8'h6f, 8'hb9, 8'hab, 8'h79, 8'h5a, 8'h77};
    spm_ctrl u_spm_ctrl (.clk_sys, .srst, .cs_n_pin, .sck_pin, .si_pin, .ready_busy_flag, .query_prot,
        .query_susp, .wel_clr_ext, .prog_fail_evt, .status4_clr, .cmd_accept_q, .cmd_reject_q, .cmd_code_q,
        .prog_start_q, .prog_addr_q, .prog_data_q, .seq_abort_q, .query_addr_q, .write_latch_flag_q,
        .seq_prog_mode_flag_q, .erase_error_flag_q, .prog_fail_flag_q);
    spm_host_model u_spm_host_model (.clk_sys, .cs_n_pin, .sck_pin, .si_pin);
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        query_prot <= query_addr_q[23:12] == prot_blk;
        query_susp <= query_addr_q[23:16] == susp_blk;
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
        checks++;
        if (e !== g) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic flags(input logic [1:0] e);
        chk("latch and mode", {31'h0, e}, {31'h0, write_latch_flag_q, seq_prog_mode_flag_q});
    endtask : flags
    task automatic frame(input logic [63:0] b, input int n, input logic [32:0] r);
        exp_cmd.push_back({1'b1, b[n-1 -: 8]});
        exp_res.push_back(r);
        u_spm_host_model.send(b, n);
    endtask : frame
    task automatic cmd(input logic [7:0] op, input logic acc);
        exp_cmd.push_back({acc, op});
        u_spm_host_model.send({56'h0, op}, 8);
    endtask : cmd
    always @(posedge clk_sys) begin
        if (cmd_accept_q || cmd_reject_q)
            chk("command", {24'h0, exp_cmd.pop_front()}, {24'h0, cmd_accept_q, cmd_code_q});
        if (prog_start_q || seq_abort_q)
            chk("program", exp_res.pop_front(), seq_abort_q ? 33'h100000000 : {1'b0, prog_addr_q, prog_data_q});
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (60000) @(posedge clk_sys);
        num_errors++;
        give_verdict();
    end
    initial begin
        {srst, ready_busy_flag, wel_clr_ext, prog_fail_evt, status4_clr} = 5'h10;
        seed = 32'h9716;
        prot_blk = 12'h002;
        susp_blk = 8'hff;
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        flags(2'b00);
        cmd(OP_WREN, 1'b1);
        d = rnd();
        frame({OP_SEQ_A, 24'h001ffe, rnd(), d}, 48, {1'b0, 24'h001ffe, d});
        flags(2'b11);
        for (int i = 0; i < 35; i++) cmd(ops[i], i < 9);
        d = rnd();
        frame({OP_SEQ_B, d}, 16, {1'b0, 24'h001fff, d});
        flags(2'b00);
        $display("entry, filter and protected exit done");
        @(posedge clk_sys) ready_busy_flag <= 1'b1;
        cmd(8'h03, 1'b0);
        cmd(OP_RDSR1, 1'b1);
        cmd(OP_WREN, 1'b0);
        cmd(OP_TERM, 1'b1);
        @(posedge clk_sys) ready_busy_flag <= 1'b0;
        cmd(OP_WREN, 1'b1);
        frame({OP_SEQ_A, 24'h000100, 4'h5}, 36, 33'h100000000);
        flags(2'b00);
        cmd(OP_WREN, 1'b1);
        frame({OP_SEQ_A, 24'h002010, rnd()}, 40, 33'h100000000);
        flags(2'b00);
        $display("busy and abort done");
        cmd(OP_WREN, 1'b1);
        d = rnd();
        frame({OP_SEQ_A, LAST_ADDR, d}, 40, {1'b0, LAST_ADDR, d});
        flags(2'b00);
        susp_blk = 8'h01;
        cmd(OP_WREN, 1'b1);
        d = rnd();
        frame({OP_SEQ_A, 24'h00ffff, d}, 40, {1'b0, 24'h00ffff, d});
        flags(2'b10);
        d = rnd();
        frame({OP_SEQ_A, 24'h000300, d}, 40, {1'b0, 24'h000300, d});
        flags(2'b11);
        cmd(OP_WRDI, 1'b1);
        flags(2'b00);
        cmd(OP_WREN, 1'b1);
        d = rnd();
        frame({OP_SEQ_A, 24'h000200, d}, 40, {1'b0, 24'h000200, d});
        flags(2'b11);
        @(posedge clk_sys) wel_clr_ext <= 1'b1;
        @(posedge clk_sys) wel_clr_ext <= 1'b0;
        repeat (2) @(posedge clk_sys);
        flags(2'b00);
        @(posedge clk_sys) prog_fail_evt <= 1'b1;
        @(posedge clk_sys) prog_fail_evt <= 1'b0;
        @(posedge clk_sys) status4_clr <= 1'b1;
        chk("status four", 33'h3, {31'h0, erase_error_flag_q, prog_fail_flag_q});
        @(posedge clk_sys) status4_clr <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("status four clear", 33'h0, {31'h0, erase_error_flag_q, prog_fail_flag_q});
        @(posedge clk_sys) {prog_fail_evt, status4_clr} <= 2'b11;
        @(posedge clk_sys) {prog_fail_evt, status4_clr} <= 2'b00;
        @(posedge clk_sys);
        chk("status four set wins", 33'h3, {31'h0, erase_error_flag_q, prog_fail_flag_q});
        chk("queues empty", 33'h0, 33'(exp_cmd.size() + exp_res.size()));
        $display("mode exits and status done");
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
